/* design/dea_map.vh */
// Register map, field positions and reset values of the error aggregation block
`ifndef DEA_MAP_VH
`define DEA_MAP_VH
`define DEA_RAM_SBE_MSK 16'h00f0
`define DEA_RAM_SBE_STS 16'h00f4
`define DEA_RAM_DBE_MSK 16'h00f8
`define DEA_RAM_DBE_STS 16'h00fc
`define DEA_CTRL_STAT 16'h0248
`define DEA_CTRL_MASK 16'h024c
`define DEA_DSC_STS 16'h0254
`define DEA_DSC_MSK 16'h0258
`define DEA_DSC_LOG 16'h025c
`define DEA_TRQ_STS 16'h0260
`define DEA_TRQ_MSK 16'h0264
`define DEA_TRQ_LOG 16'h0268
`define DEA_LINK_STS 16'h026c
`define DEA_STM_STS 16'h0af0
`define DEA_STM_MSK 16'h0af4
`define DEA_FAT_STS 16'h0af8
`define DEA_FAT_MSK 16'h0afc
`define DEA_FAT_ACT 16'h0b00
`define DEA_INT_CTL 16'h0b04
`define DEA_FIRST_QID 16'h0b30
`define DEA_CMM_STATE 16'h1040
`define DEA_CMM_CMSK 16'h1054
`define DEA_CMM_CODE 16'h1058
`define DEA_CMM_INFO 16'h105c
`define DEA_HMM_STATE 16'h1240
`define DEA_HMM_CMSK 16'h1254
`define DEA_HMM_CODE 16'h1258
`define DEA_HMM_INFO 16'h125c
// Central status bit of each leaf
`define DEA_B_RSBE 0
`define DEA_B_RDBE 1
`define DEA_B_DSC 2
`define DEA_B_TRQ 3
`define DEA_B_STM 4
`define DEA_B_CMM 5
`define DEA_B_HMM 6
`define DEA_B_LNK 7
`define DEA_NLEAF 8
// Fatal action bits, interrupt control bit, link status bits
`define DEA_ACT_STOP 0
`define DEA_ACT_INV 1
`define DEA_INT_EN 0
`define DEA_LNK_DOWN 0
`define DEA_LNK_PAR 1
`define DEA_ZERO32 32'h0000_0000
`define DEA_ONES32 32'hffff_ffff
`define DEA_QID_NONE 1'b0
`define DEA_HTRANS_NSEQ 2'b10
`define DEA_HSIZE_WORD 3'b010
`endif

/* design/dea_leaf.v */
// One leaf collector: sticky status with write-one-to-clear and a forwarding mask
`timescale 1ns/10ps
`include "dea_map.vh"
module dea_leaf #(
  parameter W = 32
) (
  clk,
  rst_b,
  err_in,
  clr_we,
  clr_data,
  mask_we,
  mask_data,
  status_r,
  mask_r,
  fwd
);
  input wire clk;
  input wire rst_b;
  input wire [W-1:0] err_in;
  input wire clr_we;
  input wire [W-1:0] clr_data;
  input wire mask_we;
  input wire [W-1:0] mask_data;
  output reg [W-1:0] status_r;
  output reg [W-1:0] mask_r;
  output wire fwd;

  wire [W-1:0] clr_bits;
  assign clr_bits = clr_we ? clr_data : {W{1'b0}};

  always @(posedge clk) begin
    if (!rst_b) begin
      status_r <= {W{1'b0}};
      mask_r <= {W{1'b0}};
    end else begin
      // A new error wins over a clear in the same cycle; mask ignored here
      status_r <= (status_r & ~clr_bits) | err_in; // see [R5] see [R7] see [R23]
      if (mask_we) begin
        mask_r <= mask_data;
      end
    end
  end

  assign fwd = |(status_r & mask_r); // see [R6] see [R1]
endmodule // dea_leaf

/* design/dea_code_log.v */
// Memory-mapped leaf: first-error code and info capture gated by a code enable mask
`timescale 1ns/10ps
`include "dea_map.vh"
module dea_code_log (
  clk,
  rst_b,
  err_valid,
  err_code,
  err_info,
  cmsk_we,
  wdata,
  clr_we,
  cmsk_r,
  code_r,
  info_r,
  pend
);
  input wire clk;
  input wire rst_b;
  input wire err_valid;
  input wire [4:0] err_code;
  input wire [31:0] err_info;
  input wire cmsk_we;
  input wire [31:0] wdata;
  input wire clr_we;
  output reg [31:0] cmsk_r;
  output reg [31:0] code_r;
  output reg [31:0] info_r;
  output wire pend;

  reg valid_r;
  wire hit;
  assign hit = err_valid && cmsk_r[err_code];

  always @(posedge clk) begin
    if (!rst_b) begin
      cmsk_r <= `DEA_ONES32;
      code_r <= `DEA_ZERO32;
      info_r <= `DEA_ZERO32;
      valid_r <= 1'b0;
    end else begin
      if (cmsk_we) begin
        cmsk_r <= wdata;
      end
      // Keep the first enabled error; a clear in the same cycle loses to it
      if (hit && (!valid_r || clr_we)) begin // see [R12] see [R13]
        code_r <= {27'h0000000, err_code};
        info_r <= err_info;
        valid_r <= 1'b1;
      end else if (clr_we) begin
        valid_r <= 1'b0;
      end
    end
  end

  assign pend = valid_r;
endmodule // dea_code_log

/* design/dea_top.v */
// Two-level error aggregation with fatal handling, link and parity checks, AHB-Lite regs
// Function
// [R1] Each leaf logs its own errors and forwards them to the central collector.
// [R2] Central status bits show which leaf holds a pending error.
// [R3] Central mask bit set passes a leaf error toward the interrupt.
// [R4] The error interrupt control register gates interrupt generation.
// [R5] Leaf status bits set by hardware, cleared only by writing one; the code clears the memory-mapped leaf state on any write to it.
// [R6] Leaf mask bit set forwards the logged error upward.
// [R7] Logging happens regardless of the mask.
// [R8] Streaming leaf has its own status and mask registers.
// [R9] Queue id of the first streaming error is held readable.
// [R10] Target request error logs select, function and address.
// [R11] Descriptor error logs queue id, direction and consumer index.
// [R12] Card-to-host memory leaf has code mask, code and info registers.
// [R13] Host-to-card memory leaf has code mask, code, info and status.
// [R14] Fatal mask routes a streaming fatal error to fatal handling.
// [R15] Fatal stop action disables the write request path.
// [R16] Fatal invert action inverts write payload parity.
// [R17] Interfaces keep running on link loss; outstanding reads still answered.
// [R18] Link loss is recorded as an error in a status register.
// [R19] Requests with bad parity are dropped and a fatal error recorded; the code logs it in the link status parity bit, not as a fatal error.
// [R20] Double-bit errors on bridge slave data report as parity errors.
// [R21] Parity passes unchanged; parity errors detected on all data paths.
// [R22] One odd parity bit per data byte in the user sideband.
// [R23] Logged status bits stay set until software clears them.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/10ps
`include "dea_map.vh"
module dea_top #(
  parameter DW = 64,
  parameter QW = 11
) (
  clk,
  rst_b,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hresp,
  hrdata,
  ram_sbe,
  ram_dbe,
  dsc_err,
  dsc_qid,
  dsc_dir,
  dsc_cidx,
  trq_err,
  trq_sel,
  trq_func,
  trq_addr,
  stm_err,
  stm_qid,
  stm_fatal,
  cmm_err,
  cmm_code,
  cmm_info,
  hmm_err,
  hmm_code,
  hmm_info,
  link_up,
  pay_data,
  pay_par_in,
  pay_par_out,
  req_valid,
  req_data,
  req_par,
  req_pass,
  slv_dbe,
  write_request_path_en,
  err_irq
);
  localparam PW = DW / 8;
  input wire clk;
  input wire rst_b;
  input wire hsel;
  input wire [31:0] haddr;
  input wire [1:0] htrans;
  input wire hwrite;
  input wire [2:0] hsize;
  input wire [31:0] hwdata;
  input wire hready;
  output wire hreadyout;
  output wire hresp;
  output reg [31:0] hrdata;
  input wire [31:0] ram_sbe;
  input wire [31:0] ram_dbe;
  input wire [31:0] dsc_err;
  input wire [QW-1:0] dsc_qid;
  input wire dsc_dir;
  input wire [15:0] dsc_cidx;
  input wire [31:0] trq_err;
  input wire [3:0] trq_sel;
  input wire [7:0] trq_func;
  input wire [15:0] trq_addr;
  input wire [31:0] stm_err;
  input wire [QW-1:0] stm_qid;
  input wire [31:0] stm_fatal;
  input wire cmm_err;
  input wire [4:0] cmm_code;
  input wire [31:0] cmm_info;
  input wire hmm_err;
  input wire [4:0] hmm_code;
  input wire [31:0] hmm_info;
  input wire link_up;
  input wire [DW-1:0] pay_data;
  input wire [PW-1:0] pay_par_in;
  output reg [PW-1:0] pay_par_out;
  input wire req_valid;
  input wire [DW-1:0] req_data;
  input wire [PW-1:0] req_par;
  output reg req_pass;
  input wire slv_dbe;
  output reg write_request_path_en;
  output reg err_irq;

  // Odd parity: each byte plus its parity bit holds an odd count of ones
  function [PW-1:0] odd_par;
    input [DW-1:0] d;
    integer i;
    begin
      for (i = 0; i < PW; i = i + 1) begin
        odd_par[i] = ~^d[i*8 +: 8]; // see [R22]
      end
    end
  endfunction

  // AHB-Lite slave: zero wait states, always OKAY
  // Read data is picked at the address phase so that it stands as a flop output
  reg wr_pend_r;
  reg [15:0] addr_r;
  reg [31:0] rd_word;
  wire acc;
  assign acc = hsel && hready && (htrans == `DEA_HTRANS_NSEQ) && (hsize == `DEA_HSIZE_WORD);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge clk) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      addr_r <= 16'h0000;
    end else begin
      wr_pend_r <= acc && hwrite;
      if (acc) begin
        addr_r <= haddr[15:0];
      end
    end
  end

  // Writes decode from the registered address; hwdata only stands in the data phase
  function wsel;
    input [15:0] a;
    begin
      wsel = wr_pend_r && (addr_r == a);
    end
  endfunction

  // Synchronise the link-up pin: three stages, change once stages 2 and 3 agree
  reg [2:0] lnk_s_r;
  reg lnk_r;
  always @(posedge clk) begin
    if (!rst_b) begin
      lnk_s_r <= 3'b000;
      lnk_r <= 1'b0;
    end else begin
      lnk_s_r <= {lnk_s_r[1:0], link_up};
      if (lnk_s_r[1] == lnk_s_r[2]) begin
        lnk_r <= lnk_s_r[2];
      end
    end
  end
  // Only a settled fall counts, so a glitch on the pin cannot log a link loss
  wire lnk_fall;
  assign lnk_fall = lnk_r && (lnk_s_r[1] == lnk_s_r[2]) && !lnk_s_r[2];

  // Request parity check: bad requests are withheld toward the link
  wire req_bad;
  assign req_bad = req_valid && (odd_par(req_data) != req_par);
  wire pay_bad;
  assign pay_bad = odd_par(pay_data) != pay_par_in;

  // Leaf instances
  wire [31:0] rs_sts, rs_msk, rd_sts, rd_msk, ds_sts, ds_msk, tq_sts, tq_msk;
  wire [31:0] st_sts, st_msk, fa_sts, fa_msk, lk_sts;
  wire [`DEA_NLEAF-1:0] leaf_fwd;
  wire fat_fwd;
  wire [31:0] lnk_ev;
  assign lnk_ev = {30'h00000000, req_bad || slv_dbe, lnk_fall}; // see [R18] see [R19] see [R20]
  wire [31:0] stm_ev;
  // Write payload parity errors on the streaming path also log here
  assign stm_ev = stm_err | {31'h00000000, pay_bad}; // see [R21]

  dea_leaf u_rsbe (.clk(clk), .rst_b(rst_b), .err_in(ram_sbe),
    .clr_we(wsel(`DEA_RAM_SBE_STS)), .clr_data(hwdata),
    .mask_we(wsel(`DEA_RAM_SBE_MSK)), .mask_data(hwdata),
    .status_r(rs_sts), .mask_r(rs_msk), .fwd(leaf_fwd[`DEA_B_RSBE]));
  dea_leaf u_rdbe (.clk(clk), .rst_b(rst_b), .err_in(ram_dbe),
    .clr_we(wsel(`DEA_RAM_DBE_STS)), .clr_data(hwdata),
    .mask_we(wsel(`DEA_RAM_DBE_MSK)), .mask_data(hwdata),
    .status_r(rd_sts), .mask_r(rd_msk), .fwd(leaf_fwd[`DEA_B_RDBE]));
  dea_leaf u_dsc (.clk(clk), .rst_b(rst_b), .err_in(dsc_err),
    .clr_we(wsel(`DEA_DSC_STS)), .clr_data(hwdata),
    .mask_we(wsel(`DEA_DSC_MSK)), .mask_data(hwdata),
    .status_r(ds_sts), .mask_r(ds_msk), .fwd(leaf_fwd[`DEA_B_DSC]));
  dea_leaf u_trq (.clk(clk), .rst_b(rst_b), .err_in(trq_err),
    .clr_we(wsel(`DEA_TRQ_STS)), .clr_data(hwdata),
    .mask_we(wsel(`DEA_TRQ_MSK)), .mask_data(hwdata),
    .status_r(tq_sts), .mask_r(tq_msk), .fwd(leaf_fwd[`DEA_B_TRQ]));
  dea_leaf u_stm (.clk(clk), .rst_b(rst_b), .err_in(stm_ev),
    .clr_we(wsel(`DEA_STM_STS)), .clr_data(hwdata),
    .mask_we(wsel(`DEA_STM_MSK)), .mask_data(hwdata),
    .status_r(st_sts), .mask_r(st_msk), .fwd(leaf_fwd[`DEA_B_STM])); // see [R8]
  dea_leaf u_fat (.clk(clk), .rst_b(rst_b), .err_in(stm_fatal),
    .clr_we(wsel(`DEA_FAT_STS)), .clr_data(hwdata),
    .mask_we(wsel(`DEA_FAT_MSK)), .mask_data(hwdata),
    .status_r(fa_sts), .mask_r(fa_msk), .fwd(fat_fwd)); // see [R14]
  dea_leaf u_lnk (.clk(clk), .rst_b(rst_b), .err_in(lnk_ev),
    .clr_we(wsel(`DEA_LINK_STS)), .clr_data(hwdata),
    .mask_we(1'b0), .mask_data(hwdata),
    .status_r(lk_sts), .mask_r(), .fwd());
  // Link leaf has no mask register: a link loss always reaches its central bit
  assign leaf_fwd[`DEA_B_LNK] = |lk_sts;

  // Memory-mapped leaves report pending while a first error is held
  wire [31:0] cm_cmsk, cm_code, cm_info, hm_cmsk, hm_code, hm_info;
  dea_code_log u_cmm (.clk(clk), .rst_b(rst_b), .err_valid(cmm_err),
    .err_code(cmm_code), .err_info(cmm_info), .cmsk_we(wsel(`DEA_CMM_CMSK)),
    .wdata(hwdata), .clr_we(wsel(`DEA_CMM_STATE)), .cmsk_r(cm_cmsk),
    .code_r(cm_code), .info_r(cm_info), .pend(leaf_fwd[`DEA_B_CMM]));
  dea_code_log u_hmm (.clk(clk), .rst_b(rst_b), .err_valid(hmm_err),
    .err_code(hmm_code), .err_info(hmm_info), .cmsk_we(wsel(`DEA_HMM_CMSK)),
    .wdata(hwdata), .clr_we(wsel(`DEA_HMM_STATE)), .cmsk_r(hm_cmsk),
    .code_r(hm_code), .info_r(hm_info), .pend(leaf_fwd[`DEA_B_HMM]));

  // Central collector, logs, fatal actions
  reg [31:0] cmask_r;
  reg [31:0] fact_r;
  reg [31:0] ictl_r;
  reg [31:0] dsc_log_r;
  reg [31:0] trq_log_r;
  reg [31:0] qid_r;
  reg qid_vld_r;
  reg fatal_r;
  wire [31:0] cstat;
  assign cstat = {{(32 - `DEA_NLEAF){1'b0}}, leaf_fwd}; // see [R2] see [R1]

  always @(posedge clk) begin
    if (!rst_b) begin
      cmask_r <= `DEA_ZERO32;
      fact_r <= `DEA_ZERO32;
      ictl_r <= `DEA_ZERO32;
      dsc_log_r <= `DEA_ZERO32;
      trq_log_r <= `DEA_ZERO32;
      qid_r <= `DEA_ZERO32;
      qid_vld_r <= `DEA_QID_NONE;
      fatal_r <= 1'b0;
      err_irq <= 1'b0;
      write_request_path_en <= 1'b1;
      pay_par_out <= {PW{1'b0}};
      req_pass <= 1'b0;
    end else begin
      if (wsel(`DEA_CTRL_MASK)) begin
        cmask_r <= hwdata;
      end
      if (wsel(`DEA_FAT_ACT)) begin
        fact_r <= hwdata;
      end
      if (wsel(`DEA_INT_CTL)) begin
        ictl_r <= hwdata;
      end
      if (|dsc_err) begin
        dsc_log_r <= {dsc_cidx, dsc_dir, {(15 - QW){1'b0}}, dsc_qid}; // see [R11]
      end
      if (|trq_err) begin
        trq_log_r <= {trq_sel, trq_func, 4'h0, trq_addr}; // see [R10]
      end
      // First streaming error holds its queue until the status is fully cleared
      if (|stm_err && !qid_vld_r) begin
        qid_r <= {{(32 - QW){1'b0}}, stm_qid}; // see [R9]
        qid_vld_r <= 1'b1;
      end else if (st_sts == `DEA_ZERO32) begin
        qid_vld_r <= `DEA_QID_NONE;
      end
      // Inversion starts two cycles after the fatal mask passes the error, one cycle after the write stop
      fatal_r <= fat_fwd;
      err_irq <= ictl_r[`DEA_INT_EN] && |(cstat & cmask_r); // see [R3] see [R4]
      write_request_path_en <= !(fat_fwd && fact_r[`DEA_ACT_STOP]); // see [R15]
      // Parity passes through unless a fatal error is held and the fatal invert action is armed
      pay_par_out <= (fatal_r && fact_r[`DEA_ACT_INV]) ? ~pay_par_in : pay_par_in; // see [R16] see [R21]
      // Link loss does not stall requests; only corrupted ones are dropped
      req_pass <= req_valid && !req_bad; // see [R19] see [R17]
    end
  end

  always @* begin
    rd_word = `DEA_ZERO32;
    case (haddr[15:0])
      `DEA_RAM_SBE_MSK: rd_word = rs_msk;
      `DEA_RAM_SBE_STS: rd_word = rs_sts;
      `DEA_RAM_DBE_MSK: rd_word = rd_msk;
      `DEA_RAM_DBE_STS: rd_word = rd_sts;
      `DEA_CTRL_STAT: rd_word = cstat;
      `DEA_CTRL_MASK: rd_word = cmask_r;
      `DEA_DSC_STS: rd_word = ds_sts;
      `DEA_DSC_MSK: rd_word = ds_msk;
      `DEA_DSC_LOG: rd_word = dsc_log_r;
      `DEA_TRQ_STS: rd_word = tq_sts;
      `DEA_TRQ_MSK: rd_word = tq_msk;
      `DEA_TRQ_LOG: rd_word = trq_log_r;
      `DEA_LINK_STS: rd_word = lk_sts;
      `DEA_STM_STS: rd_word = st_sts;
      `DEA_STM_MSK: rd_word = st_msk;
      `DEA_FAT_STS: rd_word = fa_sts;
      `DEA_FAT_MSK: rd_word = fa_msk;
      `DEA_FAT_ACT: rd_word = fact_r;
      `DEA_INT_CTL: rd_word = ictl_r;
      `DEA_FIRST_QID: rd_word = qid_r;
      `DEA_CMM_STATE: rd_word = {31'h00000000, leaf_fwd[`DEA_B_CMM]};
      `DEA_CMM_CMSK: rd_word = cm_cmsk;
      `DEA_CMM_CODE: rd_word = cm_code;
      `DEA_CMM_INFO: rd_word = cm_info;
      `DEA_HMM_STATE: rd_word = {31'h00000000, leaf_fwd[`DEA_B_HMM]};
      `DEA_HMM_CMSK: rd_word = hm_cmsk;
      `DEA_HMM_CODE: rd_word = hm_code;
      `DEA_HMM_INFO: rd_word = hm_info;
      default: rd_word = `DEA_ZERO32;
    endcase
  end

  // Limitation: a read pipelined right behind a write to the same register sees the old value
  always @(posedge clk) begin
    if (!rst_b) begin
      hrdata <= `DEA_ZERO32;
    end else if (acc && !hwrite) begin
      hrdata <= rd_word;
    end else begin
      hrdata <= `DEA_ZERO32;
    end
  end
endmodule // dea_top

/* sim/dea_properties.sv */
// Port-level assertions for the error aggregation block
`timescale 1ns/10ps
module dea_checker #(
  parameter DW = 64
) (
  input logic clk,
  input logic rst_b,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  input logic [31:0] hrdata,
  input logic [31:0] ram_sbe,
  input logic [31:0] ram_dbe,
  input logic [31:0] dsc_err,
  input logic [31:0] trq_err,
  input logic [31:0] stm_err,
  input logic [31:0] stm_fatal,
  input logic cmm_err,
  input logic hmm_err,
  input logic slv_dbe,
  input logic link_up,
  input logic [DW-1:0] pay_data,
  input logic [DW/8-1:0] pay_par_in,
  input logic [DW/8-1:0] pay_par_out,
  input logic req_valid,
  input logic [DW-1:0] req_data,
  input logic [DW/8-1:0] req_par,
  input logic req_pass,
  input logic write_request_path_en,
  input logic err_irq
);
  localparam PW = DW / 8;
  logic ph_r, wr_r, fat_r, err_r, lnk_r;
  logic [3:0] calm_r;
  logic req_ok, pay_ok, ev;
  function automatic logic odd_ok(input logic [DW-1:0] d, input logic [PW-1:0] p);
    odd_ok = 1'b1;
    for (int i = 0; i < PW; i++) odd_ok &= ^{d[8*i+:8], p[i]};
  endfunction
  assign req_ok = odd_ok(req_data, req_par);
  assign pay_ok = odd_ok(pay_data, pay_par_in);
  // Any cause that may legally raise the interrupt, link level included
  assign ev = |{ram_sbe, ram_dbe, dsc_err, trq_err, stm_err, stm_fatal, cmm_err, hmm_err,
    slv_dbe, req_valid & ~req_ok, ~pay_ok, ~link_up};
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      {ph_r, wr_r, fat_r, err_r} <= 4'h0;
      lnk_r <= 1'b1;
      calm_r <= 4'h0;
    end else begin
      ph_r <= hsel & hready & (htrans == 2'h2);
      wr_r <= hsel & hready & (htrans == 2'h2) & hwrite;
      fat_r <= fat_r | (|stm_fatal);
      err_r <= err_r | ev;
      lnk_r <= link_up;
      // Saturates so a long quiet spell cannot wrap back into the legal window
      calm_r <= (ev | wr_r | (lnk_r ^ link_up)) ? 4'h0 : calm_r + {3'h0, calm_r != 4'hf};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_rdata_idle: assert property (!ph_r |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_req_gate: assert property ($past(rst_b) |-> req_pass == $past(req_valid & req_ok))
    else $error("request pass does not follow parity check");
  a_pay_pass: assert property (!fat_r && $past(rst_b) |-> pay_par_out == $past(pay_par_in))
    else $error("payload parity altered without fatal error");
  a_pay_flip: assert property ($past(rst_b) |->
    pay_par_out == $past(pay_par_in) || pay_par_out == ~$past(pay_par_in))
    else $error("payload parity neither passed nor inverted");
  a_wrq_hold: assert property (!fat_r |-> write_request_path_en)
    else $error("write requests stopped without fatal error");
  a_irq_quiet: assert property (!err_r |-> !err_irq)
    else $error("interrupt without any error");
  a_irq_cause: assert property ($rose(err_irq) |-> calm_r < 4'h8)
    else $error("interrupt rose long after any cause");
  a_irq_sticky: assert property ($fell(err_irq) |-> $past(wr_r) || $past(wr_r, 2))
    else $error("interrupt dropped without a register write");
  cover property ($rose(err_irq));
  cover property ($fell(write_request_path_en));
  cover property (req_valid && !req_ok ##1 !req_pass);
endmodule // dea_checker

bind dea_top dea_checker #(.DW(DW)) i_chk (.clk, .rst_b, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .ram_sbe, .ram_dbe, .dsc_err, .trq_err, .stm_err, .stm_fatal,
  .cmm_err, .hmm_err, .slv_dbe, .link_up, .pay_data, .pay_par_in, .pay_par_out, .req_valid,
  .req_data, .req_par, .req_pass, .write_request_path_en, .err_irq);

/* sim/tb_dma_error_aggregation.sv */
// Self-checking bench for the error aggregation block
`timescale 1ns/10ps
module tb_dma_error_aggregation;
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, req_valid = 1'b0;
  logic cmm_err = 1'b0, hmm_err = 1'b0, slv_dbe = 1'b0, link_up = 1'b1, dsc_dir = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = '0, hwdata = '0, ram_sbe = '0, ram_dbe = '0, dsc_err = '0, trq_err = '0;
  logic [31:0] stm_err = '0, stm_fatal = '0, cmm_info = '0, hmm_info = '0, q, b;
  logic [10:0] dsc_qid = 11'h0, stm_qid = 11'h0;
  logic [15:0] dsc_cidx = 16'hbeef, trq_addr = 16'h0;
  logic [3:0] trq_sel = 4'h9;
  logic [7:0] trq_func = 8'h5a, pay_par_in = 8'hfc, req_par = 8'hff;
  logic [4:0] cmm_code = 5'h0, hmm_code = 5'h0;
  logic [63:0] pay_data = 64'h0101, req_data = '0;
  wire hready, hreadyout, hresp, req_pass, write_request_path_en, err_irq;
  wire [31:0] hrdata;
  wire [7:0] pay_par_out;
  int n_errors = 0, comparisons = 0;
  // Rows: register offset and whether it resets to all ones; 0x300 is unmapped
  logic [16:0] rows [29] = '{{16'h00f0, 1'b0}, {16'h00f4, 1'b0}, {16'h00f8, 1'b0},
    {16'h00fc, 1'b0}, {16'h0248, 1'b0}, {16'h024c, 1'b0}, {16'h0254, 1'b0}, {16'h0258, 1'b0},
    {16'h025c, 1'b0}, {16'h0260, 1'b0}, {16'h0264, 1'b0}, {16'h0268, 1'b0}, {16'h026c, 1'b0},
    {16'h0af0, 1'b0}, {16'h0af4, 1'b0}, {16'h0af8, 1'b0}, {16'h0afc, 1'b0}, {16'h0b00, 1'b0},
    {16'h0b04, 1'b0}, {16'h0b30, 1'b0}, {16'h1040, 1'b0}, {16'h1054, 1'b1}, {16'h1058, 1'b0},
    {16'h105c, 1'b0}, {16'h1240, 1'b0}, {16'h1254, 1'b1}, {16'h1258, 1'b0}, {16'h125c, 1'b0},
    {16'h0300, 1'b0}};
  logic [15:0] lf [5] = '{16'h00f4, 16'h00fc, 16'h0254, 16'h0260, 16'h0af0};
  logic [15:0] mk [8] = '{16'h00f0, 16'h00f8, 16'h0258, 16'h0264, 16'h0af4, 16'h0afc,
    16'h1054, 16'h1254};
  assign hready = hreadyout;
  always #2 clk = ~clk;
  dea_top i_dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .ram_sbe, .ram_dbe, .dsc_err, .dsc_qid, .dsc_dir, .dsc_cidx,
    .trq_err, .trq_sel, .trq_func, .trq_addr, .stm_err, .stm_qid, .stm_fatal, .cmm_err,
    .cmm_code, .cmm_info, .hmm_err, .hmm_code, .hmm_info, .link_up, .pay_data, .pay_par_in,
    .pay_par_out, .req_valid, .req_data, .req_par, .req_pass, .slv_dbe,
    .write_request_path_en, .err_irq);
  task automatic conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic flag(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  // Entered right after a rising edge; holds each phase until ready is sampled high
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {16'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // One-cycle error event on source k; side fields follow v so logs can be predicted
  task automatic hit(input int k, input logic [31:0] v);
    dsc_qid <= v[10:0];
    trq_addr <= v[15:0];
    {cmm_code, hmm_code, cmm_info, hmm_info} <= {v[4:0], v[4:0], v, ~v};
    case (k)
      0: ram_sbe <= v;
      1: ram_dbe <= v;
      2: dsc_err <= v;
      3: trq_err <= v;
      4: stm_err <= v;
      5: cmm_err <= v[0];
      6: hmm_err <= v[0];
      default: stm_fatal <= v;
    endcase
    @(posedge clk);
    {ram_sbe, ram_dbe, dsc_err, trq_err, stm_err, stm_fatal, cmm_err, hmm_err} <= '0;
    @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) rd(rows[i][16:1], {32{rows[i][0]}});
    foreach (mk[i]) begin
      wr(mk[i], '1);
      rd(mk[i], '1);
    end
    wr(16'h024c, 32'hff);
    wr(16'h0b04, 32'h1);
    for (int k = 0; k < 5; k++) begin
      hit(k, 32'h20);
      rd(lf[k], 32'h20);
      if (k == 2) rd(16'h025c, 32'hbeef_8020);
      if (k == 3) rd(16'h0268, 32'h95a0_0020);
      rd(16'h0248, 32'h1 << k);
      flag("irq", 1'b1, err_irq);
      wr(lf[k], 32'h10);
      rd(lf[k], 32'h20);
      wr(lf[k], 32'h20);
      rd(lf[k], 32'h0);
      rd(16'h0248, 32'h0);
      flag("irq", 1'b0, err_irq);
    end
    stm_qid <= 11'h007;
    hit(4, 32'h2);
    stm_qid <= 11'h009;
    hit(4, 32'h4);
    bus(1'b0, 16'h0b30, '0);
    chk("first qid", 32'h7, {21'h0, q[10:0]});
    rd(16'h0af0, 32'h6);
    wr(16'h0af0, 32'h6);
    wr(16'h0af4, '0);
    hit(4, 32'h8);
    rd(16'h0af0, 32'h8);
    rd(16'h0248, 32'h0);
    wr(16'h0af4, 32'h8);
    rd(16'h0248, 32'h10);
    flag("irq", 1'b1, err_irq);
    wr(16'h024c, 32'hef);
    repeat (2) @(posedge clk);
    flag("irq", 1'b0, err_irq);
    wr(16'h024c, 32'hff);
    hsize <= 3'h0;
    wr(16'h024c, 32'h0);
    hsize <= 3'h2;
    rd(16'h024c, 32'hff);
    wr(16'h0b04, 32'h0);
    repeat (2) @(posedge clk);
    flag("irq", 1'b0, err_irq);
    wr(16'h0b04, 32'h1);
    repeat (2) @(posedge clk);
    flag("irq", 1'b1, err_irq);
    wr(16'h0af0, 32'h8);
    for (int m = 0; m < 2; m++) begin
      b = 32'h1040 + 32'h200 * m;
      // Code 1 disabled first: the error must leave no trace
      wr(b[15:0] + 16'h14, 32'hffff_fffd);
      hit(5 + m, 32'h1);
      rd(b[15:0], 32'h0);
      wr(b[15:0] + 16'h14, '1);
      hit(5 + m, 32'h1);
      rd(b[15:0], 32'h1);
      rd(b[15:0] + 16'h18, 32'h1);
      rd(b[15:0] + 16'h1c, m ? 32'hffff_fffe : 32'h1);
      rd(16'h0248, 32'h20 << m);
      wr(b[15:0], 32'h0);
      rd(b[15:0], 32'h0);
    end
    req_valid <= 1'b1;
    req_data <= 64'h1;
    req_par <= 8'hfe;
    @(posedge clk);
    req_data <= '0;
    @(posedge clk);
    flag("pass", 1'b1, req_pass);
    req_valid <= 1'b0;
    @(posedge clk);
    flag("pass", 1'b0, req_pass);
    rd(16'h026c, 32'h2);
    wr(16'h026c, 32'h2);
    slv_dbe <= 1'b1;
    @(posedge clk);
    slv_dbe <= 1'b0;
    @(posedge clk);
    rd(16'h026c, 32'h2);
    wr(16'h026c, 32'h2);
    link_up <= 1'b0;
    repeat (6) @(posedge clk);
    rd(16'h026c, 32'h1);
    rd(16'h0248, 32'h80);
    flag("irq", 1'b1, err_irq);
    link_up <= 1'b1;
    repeat (6) @(posedge clk);
    wr(16'h026c, 32'h1);
    rd(16'h026c, 32'h0);
    pay_data <= '0;
    pay_par_in <= 8'hff;
    repeat (2) @(posedge clk);
    chk("parity", 32'hff, {24'h0, pay_par_out});
    wr(16'h0b00, 32'h3);
    wr(16'h0afc, 32'hffff_fffe);
    hit(7, 32'h1);
    repeat (2) @(posedge clk);
    flag("wrq", 1'b1, write_request_path_en);
    wr(16'h0afc, 32'h1);
    hit(7, 32'h1);
    repeat (2) @(posedge clk);
    flag("wrq", 1'b0, write_request_path_en);
    chk("parity", 32'h0, {24'h0, pay_par_out});
    rd(16'h0af8, 32'h1);
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    flag("wrq", 1'b1, write_request_path_en);
    rd(16'h0af8, 32'h0);
    conclude;
  end
endmodule // tb_dma_error_aggregation
